// *** logic/emb_pkg.sv ***
`default_nettype none
package emb_pkg;

   // -----------------------------------------------------------------
   // Register map: printed offsets are register indices, byte address = 4 x index.
   // -----------------------------------------------------------------
   localparam logic [7:0] IDX_SP  = 8'h81;
   localparam logic [7:0] IDX_SPX = 8'h9E;
   localparam logic [7:0] IDX_AUX = 8'h8E;

   localparam logic [7:0] SP_RST  = 8'h07;
   localparam logic [3:0] SPX_RST = 4'h0;
   localparam logic [4:0] AUX_RST = 5'h00;

   // -----------------------------------------------------------------
   // Field positions of aux_control.
   // -----------------------------------------------------------------
   localparam int unsigned AUX_LATCH_IDLE_LOW_SEL  = 0;
   localparam int unsigned AUX_EXTERNAL_ONLY_MAP = 1;
   localparam int unsigned AUX_WS_LO = 2;
   localparam int unsigned AUX_WS_HI = 3;
   localparam int unsigned AUX_BIG_STACK_EN  = 4;

   // -----------------------------------------------------------------
   // Memory map and timing counts.
   // -----------------------------------------------------------------
   localparam logic [15:0] EXTRA_LIMIT  = 16'h1000;
   localparam logic [1:0]  STK_CNT      = 2'h1;
   localparam logic [1:0]  STK_CNT_EXT  = 2'h2;
   localparam logic [1:0]  RCVR_CNT     = 2'h3;
   localparam int unsigned AVS_ADDR_MIN = 10;

   // -----------------------------------------------------------------
   // Carriers.
   // -----------------------------------------------------------------
   typedef enum logic {
      EMB_PUSH,
      EMB_POP
   } emb_stk_op_t;

   typedef struct packed {
      logic        valid;
      emb_stk_op_t op;
      logic [7:0]  wdata;
   } emb_stk_req_t;

   typedef struct packed {
      logic        valid;
      logic        paged;
      logic        write;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } emb_xreq_t;

   typedef struct packed {
      logic        valid;
      logic        sel_extra;
      logic        we;
      logic [11:0] addr;
      logic [7:0]  wdata;
   } emb_int_req_t;

endpackage
`default_nettype wire

// *** logic/emb_sync.sv ***
`default_nettype none
module emb_sync #(
   parameter int unsigned WIDTH = 8
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] q;
   } emb_sync_st_t;

   emb_sync_st_t s;
   emb_sync_st_t n;

   if (WIDTH < 1) begin : g_chk
      $error("emb_sync needs WIDTH of at least one.");
   end

   // A new value is taken only once the second and third stages agree.
   always_comb begin
      n    = s;
      n.s1 = d;
      n.s2 = s.s1;
      n.s3 = s.s2;
      if (s.s2 == s.s3) begin
         n.q = s.s3;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign q = s.q;

endmodule
`default_nettype wire

// *** logic/emb_ctrl.sv ***
`default_nettype none
module emb_ctrl #(
   parameter int unsigned AVS_ADDR_W = 10
) (
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire logic [AVS_ADDR_W-1:0] avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic [31:0]           avs_writedata,
   output logic      [31:0]           avs_readdata,
   output logic                       avs_waitrequest,
   input  wire emb_pkg::emb_stk_req_t stk_req,
   output logic                       stk_done,
   output logic      [7:0]            stk_rdata,
   input  wire emb_pkg::emb_xreq_t    x_req,
   output logic                       x_done,
   output logic      [7:0]            x_rdata,
   output logic                       busy,
   input  wire logic [7:0]            page_high,
   output emb_pkg::emb_int_req_t      int_req,
   input  wire logic [7:0]            int_rdata,
   input  wire logic [7:0]            p0_idle_out,
   input  wire logic                  p0_idle_oe,
   input  wire logic [7:0]            p0_in,
   output logic      [7:0]            p0_out,
   output logic                       p0_oe,
   output logic      [7:0]            p2_out,
   output logic                       ale,
   output logic                       rd_n,
   output logic                       wr_n
);
   import emb_pkg::*;

   // ---------------------------------------------------------------
   // State.
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      EMB_IDLE,
      EMB_STK,
      EMB_INT,
      EMB_ADDR,
      EMB_HOLD,
      EMB_STRB,
      EMB_RCVR
   } emb_st_t;

   typedef struct packed {
      emb_st_t      st;
      logic [7:0]   sp;
      logic [3:0]   stack_pointer_high_reg;
      logic [4:0]   aux;
      logic [1:0]   cnt;
      logic [1:0]   ws;
      logic         we;
      logic [7:0]   wdata;
      logic         waitreq;
      logic [31:0]  rdata;
      logic         int_ack;
      emb_int_req_t int_req;
      logic         stk_done;
      logic [7:0]   stk_rdata;
      logic         x_done;
      logic [7:0]   x_rdata;
      logic         busy;
      logic         ale;
      logic         rd_n;
      logic         wr_n;
      logic [7:0]   p0_out;
      logic         p0_oe;
      logic [7:0]   p2_out;
   } emb_state_t;

   localparam emb_state_t RST_STATE = '{st: EMB_IDLE, sp: SP_RST, stack_pointer_high_reg: SPX_RST, aux: AUX_RST,
                                        waitreq: 1'b1, ale: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                                        default: '0};

   emb_state_t  s;
   emb_state_t  n;
   logic        take_s;
   logic        take_x;
   logic        ext;
   logic [11:0] ptr;
   logic [15:0] xaddr;
   logic [7:0]  reg_byte;
   logic [7:0]  p0_q;

   if (AVS_ADDR_W < AVS_ADDR_MIN) begin : g_chk
      $error("emb_ctrl needs AVS_ADDR_W of at least ten bits.");
   end

   emb_sync #(
      .WIDTH(8)
   ) u_p0_sync (
      .clk  (clk),
      .rst_n(rst_n),
      .d    (p0_in),
      .q    (p0_q)
   );

   // ---------------------------------------------------------------
   // Next state.
   // ---------------------------------------------------------------
   always_comb begin
      n               = s;
      n.stk_done      = 1'b0;
      n.x_done        = 1'b0;
      n.int_req.valid = 1'b0;
      n.waitreq       = 1'b1;
      n.int_ack       = s.int_req.valid;
      take_s          = 1'b0;
      take_x          = 1'b0;
      ext             = s.aux[AUX_BIG_STACK_EN];
      ptr             = ext ? {s.stack_pointer_high_reg, s.sp} : {4'h0, s.sp};
      xaddr           = x_req.paged ? {page_high, x_req.addr[7:0]} : x_req.addr;
      reg_byte        = 8'h00;
      unique case (avs_address[9:2])
         IDX_SP:  reg_byte = s.sp;
         IDX_SPX: reg_byte = {4'h0, s.stack_pointer_high_reg};
         IDX_AUX: reg_byte = {3'h0, s.aux};
         default: reg_byte = 8'h00;
      endcase
      if (avs_write && !s.waitreq) begin
         unique case (avs_address[9:2])
            IDX_SP:  n.sp = avs_writedata[7:0];
            IDX_SPX: n.stack_pointer_high_reg = avs_writedata[3:0];
            IDX_AUX: n.aux = avs_writedata[4:0];
            default: n.sp = s.sp;
         endcase
      end
      unique case (s.st)
         EMB_IDLE: begin
            n.ale    = !n.aux[AUX_LATCH_IDLE_LOW_SEL];
            n.p0_out = p0_idle_out;
            n.p0_oe  = p0_idle_oe;
            if (s.waitreq && !s.stk_done && !s.x_done) begin
               if (stk_req.valid) begin
                  take_s = 1'b1;
               end else if (x_req.valid) begin
                  take_x = 1'b1;
               end else if (avs_read || avs_write) begin
                  n.waitreq = 1'b0;
                  n.rdata   = {24'h000000, reg_byte};
               end
            end
            if (take_s) begin
               n.int_req.sel_extra = ext;
               n.int_req.we        = (stk_req.op == EMB_PUSH);
               n.int_req.wdata     = stk_req.wdata;
               n.int_req.valid     = 1'b1;
               if (stk_req.op == EMB_PUSH) begin
                  // Normal mode wraps in 8 bits and never touches the high nibble.
                  n.int_req.addr = ext ? ptr + 12'h001 : {4'h0, s.sp + 8'h01};
                  n.sp           = n.int_req.addr[7:0];
                  if (ext) begin
                     n.stack_pointer_high_reg = n.int_req.addr[11:8];
                  end
               end else begin
                  n.int_req.addr = ptr;
                  n.sp           = ext ? 8'(ptr - 12'h001) : s.sp - 8'h01;
                  if (ext) begin
                     n.stack_pointer_high_reg = 4'((ptr - 12'h001) >> 8);
                  end
               end
               n.cnt = ext ? STK_CNT_EXT : STK_CNT;
               n.st  = EMB_STK;
            end
            if (take_x) begin
               n.we    = x_req.write;
               n.wdata = x_req.wdata;
               n.ws    = s.aux[AUX_WS_HI:AUX_WS_LO];
               if (!s.aux[AUX_EXTERNAL_ONLY_MAP] && (xaddr < EXTRA_LIMIT)) begin
                  n.int_req.valid     = 1'b1;
                  n.int_req.sel_extra = 1'b1;
                  n.int_req.we        = x_req.write;
                  n.int_req.addr      = xaddr[11:0];
                  n.int_req.wdata     = x_req.wdata;
                  n.cnt               = STK_CNT;
                  n.st                = EMB_INT;
               end else begin
                  n.ale    = 1'b1;
                  n.p0_out = xaddr[7:0];
                  n.p0_oe  = 1'b1;
                  n.p2_out = xaddr[15:8];
                  n.st     = EMB_ADDR;
               end
            end
         end
         EMB_STK, EMB_INT: begin
            if (s.int_ack && s.st == EMB_STK) begin
               n.stk_rdata = int_rdata;
            end
            if (s.int_ack && s.st == EMB_INT) begin
               n.x_rdata = int_rdata;
            end
            if (s.cnt == 2'h0) begin
               n.stk_done = (s.st == EMB_STK);
               n.x_done   = (s.st == EMB_INT);
               n.st       = EMB_IDLE;
            end else begin
               n.cnt = s.cnt - 2'h1;
            end
         end
         EMB_ADDR: begin
            n.ale = 1'b0;
            n.st  = EMB_HOLD;
         end
         EMB_HOLD: begin
            n.cnt = s.ws;
            n.st  = EMB_STRB;
            if (s.we) begin
               n.p0_out = s.wdata;
               n.p0_oe  = 1'b1;
               n.wr_n   = 1'b0;
            end else begin
               n.p0_oe = 1'b0;
               n.rd_n  = 1'b0;
            end
         end
         EMB_STRB: begin
            if (s.cnt == 2'h0) begin
               n.rd_n = 1'b1;
               n.wr_n = 1'b1;
               n.cnt  = RCVR_CNT;
               n.st   = EMB_RCVR;
            end else begin
               n.cnt = s.cnt - 2'h1;
            end
         end
         EMB_RCVR: begin
            // Read data reach the core through the pin synchroniser, hence the recovery wait.
            if (s.cnt == 2'h0) begin
               if (!s.we) begin
                  n.x_rdata = p0_q;
               end
               n.x_done = 1'b1;
               n.ale    = !s.aux[AUX_LATCH_IDLE_LOW_SEL];
               n.p0_out = p0_idle_out;
               n.p0_oe  = p0_idle_oe;
               n.st     = EMB_IDLE;
            end else begin
               n.cnt = s.cnt - 2'h1;
            end
         end
      endcase
      n.busy = (n.st != EMB_IDLE);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= RST_STATE;
      end else begin
         s <= n;
      end
   end

   assign avs_readdata    = s.rdata;
   assign avs_waitrequest = s.waitreq;
   assign stk_done        = s.stk_done;
   assign stk_rdata       = s.stk_rdata;
   assign x_done          = s.x_done;
   assign x_rdata         = s.x_rdata;
   assign busy            = s.busy;
   assign int_req         = s.int_req;
   assign p0_out          = s.p0_out;
   assign p0_oe           = s.p0_oe;
   assign p2_out          = s.p2_out;
   assign ale             = s.ale;
   assign rd_n            = s.rd_n;
   assign wr_n            = s.wr_n;

   // ---------------------------------------------------------------
   // Checks.
   // ---------------------------------------------------------------
   logic [2:0] strb_len;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         strb_len <= 3'h0;
      end else if (!s.rd_n || !s.wr_n) begin
         strb_len <= strb_len + 3'h1;
      end else begin
         strb_len <= 3'h0;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   stk_internal_direct_ram_a: assert property (take_s && !ext |=> !s.int_req.sel_extra && s.int_req.addr[11:8] == 4'h0
                                 && $stable(s.stack_pointer_high_reg))
      else $error("normal stack left the direct RAM or moved the high pointer");
   stk_extra_a: assert property (take_s && ext && !s.aux[AUX_EXTERNAL_ONLY_MAP] == 1'b0 |=> s.int_req.sel_extra)
      else $error("extended stack left extra RAM under external-only map");
   stk_push_addr_a: assert property (take_s && ext && stk_req.op == EMB_PUSH
                                     |=> s.int_req.valid && s.int_req.sel_extra
                                         && s.int_req.addr == {s.stack_pointer_high_reg, s.sp})
      else $error("extended push address is not the 12-bit pointer");
   stk_norm_time_a: assert property (take_s && !ext |=> !s.stk_done ##1 !s.stk_done ##1 s.stk_done)
      else $error("normal stack access did not finish in three cycles");
   stk_ext_time_a: assert property (take_s && ext |=> !s.stk_done [*3] ##1 s.stk_done)
      else $error("extended stack access did not take one extra cycle");
   map_int_a: assert property (take_x && !s.aux[AUX_EXTERNAL_ONLY_MAP] && xaddr < EXTRA_LIMIT
                               |=> s.int_req.valid && s.st == EMB_INT && s.ale == $past(s.ale))
      else $error("internally mapped move reached the external bus");
   map_ext_a: assert property (take_x && (s.aux[AUX_EXTERNAL_ONLY_MAP] || xaddr >= EXTRA_LIMIT)
                               |=> s.st == EMB_ADDR && s.ale && !s.int_req.valid
                                   && s.p2_out == $past(xaddr[15:8]))
      else $error("external move not placed on the external bus");
   idle_ale_a: assert property (s.st == EMB_IDLE && $past(s.st) == EMB_IDLE && $stable(s.aux[AUX_LATCH_IDLE_LOW_SEL])
                                |-> s.ale == !s.aux[AUX_LATCH_IDLE_LOW_SEL] && $stable(s.ale))
      else $error("latch strobe not at its idle level");
   addr_stable_a: assert property ($fell(s.ale) && s.st == EMB_HOLD
                                   |-> $stable(s.p0_out) && $stable(s.p2_out) && s.p0_oe)
      else $error("address moved at the latch strobe fall");
   strobe_width_a: assert property ($rose(s.rd_n && s.wr_n) |-> strb_len == {1'b0, s.ws} + 3'h1)
      else $error("strobe width does not match the wait select");
   port_dir_a: assert property ((!s.rd_n |-> !s.p0_oe) and (!s.wr_n |-> s.p0_oe && s.p0_out == s.wdata))
      else $error("low port direction wrong during a strobe");
   strobe_order_a: assert property ($fell(s.rd_n && s.wr_n) |-> !s.ale && !$past(s.ale))
      else $error("strobe overlaps the address phase");
   strobe_end_a: assert property ($rose(s.rd_n && s.wr_n) |-> s.st == EMB_RCVR && !s.ale)
      else $error("strobe still active at the next address phase");

   ext_read_c: cover property (take_x && !x_req.write && s.aux[AUX_EXTERNAL_ONLY_MAP] ##[1:20] s.x_done);
   ext_write_long_c: cover property (s.st == EMB_STRB && !s.wr_n && s.ws == 2'h3);
   stk_ext_c: cover property (take_s && ext ##4 s.stk_done);
   int_move_c: cover property (take_x && !s.aux[AUX_EXTERNAL_ONLY_MAP] && xaddr < EXTRA_LIMIT);

endmodule
`default_nettype wire

// *** verif/emb_xmem_model.sv ***
`default_nettype none
// -----------------------------------------------------------------
// External address latch and asynchronous RAM.
// -----------------------------------------------------------------
module emb_xmem_model (
   input  wire logic        clk,
   input  wire logic [7:0]  p0_out,
   input  wire logic        p0_oe,
   input  wire logic [7:0]  p2_out,
   input  wire logic        ale,
   input  wire logic        rd_n,
   input  wire logic        wr_n,
   output logic      [7:0]  p0_in,
   output logic      [15:0] lat_addr
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [0:65535];
   logic [7:0] last = 8'hA5;
   logic [1:0] hold = 2'h0;
   initial lat_addr = 16'h0000;
   // A released bus shows the inverted last level, so a stale byte never reads as good data.
   assign p0_in = p0_oe ? p0_out : ((!rd_n || hold != 2'h0) ? mem[lat_addr] : ~last);
   always @(posedge clk) begin
      if (p0_oe || !rd_n || hold != 2'h0) last <= p0_in;
      hold <= !rd_n ? 2'h3 : (hold != 2'h0 ? hold - 2'h1 : 2'h0);
   end
   always @(negedge ale) lat_addr <= {p2_out, p0_in};
   always @(posedge wr_n) mem[lat_addr] <= p0_in;
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
`default_nettype none
module tb_top;
   import emb_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic         clk = 1'b0;
   logic         rst_n = 1'b0;
   logic [9:0]   avs_address = 10'h000;
   logic         avs_read = 1'b0;
   logic         avs_write = 1'b0;
   logic [31:0]  avs_writedata = 32'h0;
   logic [31:0]  avs_readdata, rd;
   logic         avs_waitrequest, stk_done, x_done, p0_oe, ale, rd_n, wr_n, busy;
   logic [7:0]   idle_out = 8'h3C;
   logic         idle_oe = 1'b1;
   emb_stk_req_t stk_req = '0;
   emb_xreq_t    x_req = '0;
   emb_int_req_t int_req;
   emb_int_req_t last_ir = '0;
   logic [7:0]   stk_rdata, x_rdata, p0_in, p0_out, p2_out;
   logic [7:0]   page_high = 8'h00;
   logic [7:0]   int_rdata = 8'h00;
   logic [7:0]   iram [0:8191];
   logic [15:0]  lat_addr;
   logic         bad = 1'b0;
   logic         ale_q = 1'b1;
   int           n_errors = 0, cmp_count = 0, lat, n, sw = 0, last_w = 0, ale_rise = 0;

   emb_ctrl dut_u (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .stk_req(stk_req), .stk_done(stk_done), .stk_rdata(stk_rdata),
      .x_req(x_req), .x_done(x_done), .x_rdata(x_rdata), .busy(busy), .page_high(page_high),
      .int_req(int_req), .int_rdata(int_rdata), .p0_idle_out(idle_out), .p0_idle_oe(idle_oe), .p0_in(p0_in),
      .p0_out(p0_out), .p0_oe(p0_oe), .p2_out(p2_out), .ale(ale), .rd_n(rd_n), .wr_n(wr_n));
   emb_xmem_model xmem_u (.clk(clk), .p0_out(p0_out), .p0_oe(p0_oe), .p2_out(p2_out), .ale(ale),
      .rd_n(rd_n), .wr_n(wr_n), .p0_in(p0_in), .lat_addr(lat_addr));

   // -----------------------------------------------------------------
   // Internal RAM with one cycle of read latency, and bus monitors.
   // -----------------------------------------------------------------
   always @(posedge clk) begin
      if (int_req.valid === 1'b1) begin
         last_ir <= int_req;
         if (int_req.we) iram[{int_req.sel_extra, int_req.addr}] <= int_req.wdata;
         else int_rdata <= iram[{int_req.sel_extra, int_req.addr}];
      end
      ale_q <= ale;
      if (ale && !ale_q) ale_rise <= ale_rise + 1;
      if (!rd_n || !wr_n) sw <= sw + 1;
      else if (sw != 0) begin
         last_w <= sw;
         sw <= 0;
      end
      if ((!rd_n || !wr_n) && ale) bad <= 1'b1;
      if (!rd_n && p0_oe) bad <= 1'b1;
   end

   initial forever #5 clk = ~clk;
   initial begin
      #200000;
      n_errors++;
      stop_test();
   end

   // -----------------------------------------------------------------
   // Bus tasks and comparisons.
   // -----------------------------------------------------------------
   task automatic stop_test();
      if (n_errors == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_ir(input logic sel, input logic we, input logic [11:0] a, input logic [7:0] d);
      chk(32'({last_ir.valid, last_ir.sel_extra, last_ir.we, last_ir.addr, we ? last_ir.wdata : 8'h00}),
          32'({1'b1, sel, we, a, d}));
   endtask
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
      @(posedge clk);
      avs_address <= {idx, 2'b00};
      avs_read <= !wr;
      avs_write <= wr;
      avs_writedata <= {24'h0, wd};
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
      bus(1'b0, idx, 8'h00);
      chk(rd, exp);
   endtask
   task automatic stk(input emb_stk_op_t op, input logic [7:0] wd);
      @(posedge clk);
      stk_req <= '{1'b1, op, wd};
      lat = 0;
      do begin
         @(negedge clk);
         lat++;
         if (lat == 2) chk(busy, 1'b1);
      end while (stk_done !== 1'b1 && lat < 100);
      chk(busy, 1'b0);
      @(posedge clk);
      stk_req <= '0;
      @(negedge clk);
   endtask
   task automatic xmv(input logic pg, input logic w, input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      x_req <= '{1'b1, pg, w, a, d};
      lat = 0;
      do begin
         @(negedge clk);
         lat++;
         if (lat == 2) chk(busy, 1'b1);
      end while (x_done !== 1'b1 && lat < 100);
      chk(busy, 1'b0);
      @(posedge clk);
      x_req <= '0;
      @(negedge clk);
   endtask

   // -----------------------------------------------------------------
   // Scenarios.
   // -----------------------------------------------------------------
   task automatic t_regs();
      chk(ale, 1'b1);
      rdc(IDX_SP, {24'h0, SP_RST});
      rdc(IDX_SPX, 32'h0);
      rdc(IDX_AUX, 32'h0);
      rdc(8'h90, 32'h0);
      bus(1'b1, IDX_SPX, 8'hFF);
      rdc(IDX_SPX, 32'h0F);
   endtask
   task automatic t_stack();
      bus(1'b1, IDX_SP, 8'hFF);
      bus(1'b1, IDX_SPX, 8'h03);
      stk(EMB_PUSH, 8'h5A);
      chk(lat, 4);
      chk_ir(1'b0, 1'b1, 12'h000, 8'h5A);
      rdc(IDX_SP, 32'h00);
      rdc(IDX_SPX, 32'h03);
      stk(EMB_POP, 8'h00);
      chk(stk_rdata, 8'h5A);
      chk_ir(1'b0, 1'b0, 12'h000, 8'h00);
      bus(1'b1, IDX_AUX, 8'h12);
      bus(1'b1, IDX_SP, 8'hFF);
      bus(1'b1, IDX_SPX, 8'h05);
      stk(EMB_PUSH, 8'hC3);
      chk(lat, 5);
      chk_ir(1'b1, 1'b1, 12'h600, 8'hC3);
      rdc(IDX_SPX, 32'h06);
      stk(EMB_POP, 8'h00);
      chk(lat, 5);
      chk(stk_rdata, 8'hC3);
      rdc(IDX_SP, 32'hFF);
      rdc(IDX_SPX, 32'h05);
   endtask
   task automatic t_moves();
      bus(1'b1, IDX_AUX, 8'h00);
      xmv(1'b0, 1'b1, 16'h0123, 8'h77);
      chk(lat, 4);
      chk_ir(1'b1, 1'b1, 12'h123, 8'h77);
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, IDX_AUX, 8'(i * 4));
         xmv(1'b0, 1'b1, 16'(16'h1234 + i), 8'(8'h90 + i));
         chk(lat, 32'(9 + i));
         chk(last_w, 32'(i + 1));
         chk(lat_addr, 16'(16'h1234 + i));
         xmv(1'b0, 1'b0, 16'(16'h1234 + i), 8'h00);
         chk(x_rdata, 8'(8'h90 + i));
         chk(last_w, 32'(i + 1));
         chk({p0_oe, p0_out}, 9'h13C);
      end
      bus(1'b1, IDX_AUX, 8'h02);
      page_high <= 8'hAB;
      xmv(1'b1, 1'b1, 16'h0045, 8'h4E);
      chk(lat, 9);
      chk(lat_addr, 16'hAB45);
      xmv(1'b0, 1'b0, 16'hAB45, 8'h00);
      chk(x_rdata, 8'h4E);
      chk(bad, 1'b0);
   endtask
   task automatic t_ale();
      bus(1'b1, IDX_AUX, 8'h00);
      repeat (2) @(negedge clk);
      n = ale_rise;
      repeat (20) @(negedge clk);
      chk(ale_rise - n, 0);
      chk(ale, 1'b1);
      bus(1'b1, IDX_AUX, 8'h01);
      repeat (3) @(negedge clk);
      chk(ale, 1'b0);
      n = ale_rise;
      xmv(1'b0, 1'b0, 16'h1234, 8'h00);
      chk(ale_rise - n, 1);
      chk(ale, 1'b0);
      chk(x_rdata, 8'h90);
      @(posedge clk);
      idle_oe <= 1'b0;
      idle_out <= 8'h5A;
      repeat (2) @(negedge clk);
      chk({p0_oe, p0_out}, 9'h05A);
   endtask

   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      t_regs();
      t_stack();
      t_moves();
      t_ale();
      stop_test();
   end
endmodule
`default_nettype wire
